// ==== src/scp_pkg.sv ====
// Constants and state layout for the signaling channel preprocessor.
// Assumes one clock domain and byte-wide timeslot strobes from the
// configurable_line_interface serialiser.
package scp_pkg;

  // Control memory codes held in each location
  localparam logic [3:0] CODE_SIG = 4'ha;  // 1010: signaling field
  localparam logic [3:0] CODE_SIG8 = 4'hb; // 1011: 8-bit / odd downstream
  localparam logic [3:0] CODE_SW64 = 4'h1; // 0001: 64 kbit/s switching

  // Control memory location indices {upstream, odd}
  localparam logic [1:0] CM_DN_EVEN = 2'h0;
  localparam logic [1:0] CM_DN_ODD = 2'h1;
  localparam logic [1:0] CM_UP_EVEN = 2'h2;
  localparam logic [1:0] CM_UP_ODD = 2'h3;

  // Field positions inside one control memory word
  localparam int CM_CODE_LSB = 8;
  localparam int CM_W = 12;

  // Signaling masks for the two schemes
  localparam logic [7:0] MASK_SIG6 = 8'hfc;
  localparam logic [7:0] MASK_SIG8 = 8'hff;

  // Idle downstream byte and default handshake bits
  localparam logic [7:0] IDLE_BYTE = 8'hff;
  localparam logic [1:0] HS_ONES = 2'h3;

  // Last-look counter value after reset
  localparam logic [7:0] LL_CNT_RESET = 8'h00;

  typedef struct packed {
    logic [3:0][CM_W-1:0] cm;
    logic [7:0] dl_byte;
    logic dl_valid;
    logic [7:0] mon_up;
    logic mon_up_valid;
    logic [1:0] hs_up;
    logic [7:0] pcm_up;
    logic [1:0] pcm_up_oe_n;
    logic pcm_up_valid;
    logic [7:0] ll_prev;
    logic [7:0] ll_cnt;
    logic chg_push;
    logic irq;
    logic [CM_W-1:0] rd_data;
    logic [7:0] chg_addr;
  } scp_state_t;

  localparam scp_state_t ST_RESET = '{
    cm: '0, dl_byte: IDLE_BYTE, dl_valid: 1'b0, mon_up: 8'h00,
    mon_up_valid: 1'b0, hs_up: HS_ONES, pcm_up: 8'h00,
    pcm_up_oe_n: 2'h3, pcm_up_valid: 1'b0, ll_prev: 8'h00,
    ll_cnt: LL_CNT_RESET, chg_push: 1'b0, irq: 1'b0, rd_data: '0,
    chg_addr: 8'h00};

endpackage

// ==== src/scp_preprocessor.sv ====
// Signaling channel preprocessor for one even/odd timeslot pair.
// Assumes timeslot strobes, monitor handler bits and PCM bytes all come
// from logic on the same clock; the change FIFO sits outside.
`timescale 1ns/1ps
`default_nettype none
module scp_preprocessor
  import scp_pkg::*;
#(
  parameter logic [7:0] TS_ADDR = 8'h00
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ts_valid,
  input wire logic ts_odd,
  input wire logic [7:0] ul_byte,
  input wire logic [7:0] mon_dn_byte,
  input wire logic monitor_receive_ack_bit,
  input wire logic monitor_transmit_ready_bit,
  input wire logic hs_protocol,
  input wire logic [7:0] pcm_dn_byte,
  input wire logic tristate_low2,
  input wire logic [7:0] ll_period,
  input wire logic cm_wr,
  input wire logic [1:0] cm_addr,
  input wire logic [3:0] cm_code,
  input wire logic [7:0] cm_data,
  input wire logic [1:0] cm_rd_addr,
  output logic [7:0] dl_byte,
  output logic dl_valid,
  output logic [7:0] mon_up_byte,
  output logic mon_up_valid,
  output logic [1:0] mon_up_hs,
  output logic [7:0] pcm_up_byte,
  output logic [1:0] pcm_up_low2_oe_n,
  output logic pcm_up_valid,
  output logic change_push,
  output logic [7:0] change_addr,
  output logic sig_change_irq,
  output logic [CM_W-1:0] cm_rd_data
);

  scp_state_t s;
  scp_state_t next_s;

  logic [3:0] dn_odd_code;
  logic [3:0] up_even_code;
  logic [3:0] up_odd_code;
  logic sig_up;
  logic sig8;
  logic transp_dn;
  logic transp_up;
  logic [7:0] mask;
  logic [1:0] hs_bits;
  logic [7:0] actual_new;
  logic [7:0] stable;
  logic up_odd_strobe;
  logic sample_now;
  logic accept;

  // Scheme decode from the codes held in control memory
  assign dn_odd_code = s.cm[CM_DN_ODD][CM_W-1:CM_CODE_LSB];
  assign up_even_code = s.cm[CM_UP_EVEN][CM_W-1:CM_CODE_LSB];
  assign up_odd_code = s.cm[CM_UP_ODD][CM_W-1:CM_CODE_LSB];
  assign sig8 = (up_even_code == CODE_SIG8);
  assign sig_up = (up_even_code == CODE_SIG) || sig8;
  assign transp_dn = (dn_odd_code == CODE_SW64);
  assign transp_up = (up_odd_code == CODE_SW64);
  assign mask = sig8 ? MASK_SIG8 : MASK_SIG6;
  assign stable = s.cm[CM_UP_ODD][7:0];

  // Handshake bits: handler-driven or held at one
  assign hs_bits = hs_protocol ?
    {monitor_receive_ack_bit, monitor_transmit_ready_bit} : HS_ONES;

  // Last-look filter sampling instant and acceptance
  assign up_odd_strobe = ts_valid && ts_odd;
  assign actual_new = ul_byte & mask;
  assign sample_now = up_odd_strobe && sig_up && (s.ll_cnt == 8'h00);
  assign accept = sample_now && (actual_new == s.ll_prev)
                  && (actual_new != (stable & mask));

  // Next-state logic for the whole block
  always_comb begin
    next_s = s;
    next_s.dl_valid = 1'b0;
    next_s.mon_up_valid = 1'b0;
    next_s.pcm_up_valid = 1'b0;
    next_s.chg_push = 1'b0;
    next_s.irq = 1'b0;
    // Software writes to control memory
    if (cm_wr) begin
      next_s.cm[cm_addr] = {cm_code, cm_data};
    end
    if (ts_valid && !ts_odd) begin
      // Even slot: monitor or feature control channel both ways
      next_s.dl_byte = mon_dn_byte;
      next_s.dl_valid = 1'b1;
      next_s.mon_up = ul_byte;
      next_s.mon_up_valid = 1'b1;
    end
    if (up_odd_strobe) begin
      // Odd slot downstream: even location, PCM byte or idle byte by odd code
      next_s.dl_valid = 1'b1;
      if (dn_odd_code == CODE_SIG8) begin
        if (sig8 || !hs_protocol) begin
          next_s.dl_byte = s.cm[CM_DN_EVEN][7:0];
        end else begin
          next_s.dl_byte = {s.cm[CM_DN_EVEN][7:2], hs_bits};
        end
      end else if (transp_dn) begin
        next_s.dl_byte = {pcm_dn_byte[7:2], pcm_dn_byte[1:0] & hs_bits};
      end else begin
        next_s.dl_byte = IDLE_BYTE;
      end
      // Odd slot upstream
      next_s.hs_up = ul_byte[1:0];
      if (transp_up) begin
        next_s.pcm_up = ul_byte;
        next_s.pcm_up_valid = 1'b1;
        next_s.pcm_up_oe_n = {2{tristate_low2}};
      end
      if (sig_up) begin
        // Actual value of the latest frame
        next_s.cm[CM_UP_EVEN][7:0] = actual_new;
        if (s.ll_cnt == 8'h00) begin
          next_s.ll_prev = actual_new;
          next_s.ll_cnt = (ll_period == 8'h00) ? 8'h00 : ll_period - 8'h01;
        end else begin
          next_s.ll_cnt = s.ll_cnt - 8'h01;
        end
        if (accept) begin
          next_s.cm[CM_UP_ODD][7:0] = actual_new;
          next_s.chg_push = 1'b1;
          next_s.irq = 1'b1;
        end
      end
    end
    next_s.chg_addr = TS_ADDR;
    next_s.rd_data = next_s.cm[cm_rd_addr];
  end

  // State register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s <= ST_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register
  assign dl_byte = s.dl_byte;
  assign dl_valid = s.dl_valid;
  assign mon_up_byte = s.mon_up;
  assign mon_up_valid = s.mon_up_valid;
  assign mon_up_hs = s.hs_up;
  assign pcm_up_byte = s.pcm_up;
  assign pcm_up_low2_oe_n = s.pcm_up_oe_n;
  assign pcm_up_valid = s.pcm_up_valid;
  assign change_push = s.chg_push;
  assign change_addr = s.chg_addr;
  assign sig_change_irq = s.irq;
  assign cm_rd_data = s.rd_data;

  // Even slot monitor byte passes upstream next cycle
  a_mon_even_up: assert property (@(posedge clock) disable iff (rst)
    ts_valid && !ts_odd |=> mon_up_valid && mon_up_byte == $past(ul_byte))
    else $error("monitor byte not passed upstream");

  // Even slot downstream carries the handler byte
  a_mon_dn_even: assert property (@(posedge clock) disable iff (rst)
    ts_valid && !ts_odd |=> dl_byte == $past(mon_dn_byte))
    else $error("monitor byte not passed downstream");

  // Odd slot low bits reach the handler as handshake bits
  a_hs_up_odd: assert property (@(posedge clock) disable iff (rst)
    up_odd_strobe |=> mon_up_hs == $past(ul_byte[1:0]))
    else $error("upstream handshake bits wrong");

  // Every slot strobe gets a downstream byte the next cycle
  a_dl_every_slot: assert property (@(posedge clock) disable iff (rst)
    dl_valid == $past(ts_valid))
    else $error("downstream valid not one cycle after strobe");

  // 8-bit downstream sends the whole even location
  a_dl_sig8_byte: assert property (@(posedge clock) disable iff (rst)
    up_odd_strobe && dn_odd_code == CODE_SIG8 && sig8
    |=> dl_valid && dl_byte == $past(s.cm[CM_DN_EVEN][7:0]))
    else $error("8-bit signaling byte wrong");

  // Without handshake the even location goes out as written
  a_dl_nonhs_even: assert property (@(posedge clock) disable iff (rst)
    up_odd_strobe && dn_odd_code == CODE_SIG8 && !hs_protocol
    |=> dl_byte == $past(s.cm[CM_DN_EVEN][7:0]))
    else $error("non-handshake signaling byte wrong");

  // Unused odd codes send the idle byte
  a_dl_idle_code: assert property (@(posedge clock) disable iff (rst)
    up_odd_strobe && dn_odd_code != CODE_SIG8 && !transp_dn
    |=> dl_byte == IDLE_BYTE)
    else $error("idle byte not sent");

  // Handshake protocol puts handler bits into the odd slot
  a_dl_hs_bits: assert property (@(posedge clock) disable iff (rst)
    up_odd_strobe && dn_odd_code == CODE_SIG8 && !sig8 && hs_protocol
    |=> dl_byte[1:0] == $past({monitor_receive_ack_bit,
                                monitor_transmit_ready_bit}))
    else $error("handshake bits not from handler");

  // Transparent downstream ANDs low bits with handshake bits
  a_dl_transp_and: assert property (@(posedge clock) disable iff (rst)
    up_odd_strobe && transp_dn && dn_odd_code != CODE_SIG8
    |=> dl_byte == $past({pcm_dn_byte[7:2], pcm_dn_byte[1:0] & hs_bits}))
    else $error("transparent downstream byte wrong");

  // Transparent upstream tristate of the two low bits
  a_up_tristate: assert property (@(posedge clock) disable iff (rst)
    up_odd_strobe && transp_up
    |=> pcm_up_valid && pcm_up_low2_oe_n == {2{$past(tristate_low2)}})
    else $error("low bit tristate wrong");

  // Transparent upstream passes the whole odd byte
  a_pcm_up_byte: assert property (@(posedge clock) disable iff (rst)
    up_odd_strobe && transp_up |=> pcm_up_byte == $past(ul_byte))
    else $error("transparent upstream byte wrong");

  // No PCM byte outside a transparent odd slot
  a_pcm_up_quiet: assert property (@(posedge clock) disable iff (rst)
    !(up_odd_strobe && transp_up) |=> !pcm_up_valid)
    else $error("unexpected PCM upstream valid");

  // Actual value tracks the last frame
  a_up_actual: assert property (@(posedge clock) disable iff (rst)
    up_odd_strobe && sig_up && !(cm_wr && cm_addr == CM_UP_EVEN) |=>
    s.cm[CM_UP_EVEN][7:0] == ($past(ul_byte) & $past(mask)))
    else $error("actual value not stored");

  // Stable value moves only on an accepted change or a software write
  a_stable_guard: assert property (@(posedge clock) disable iff (rst)
    $changed(stable) |-> $past(accept) || $past(cm_wr && cm_addr == CM_UP_ODD))
    else $error("stable value changed without validation");

  // Accepted value becomes the stable value
  a_stable_load: assert property (@(posedge clock) disable iff (rst)
    accept |=> stable == $past(actual_new))
    else $error("stable value not loaded");

  // Accepted change pushes address and interrupt for one cycle
  a_change_push: assert property (@(posedge clock) disable iff (rst)
    accept |=> change_push && sig_change_irq ##1 !change_push)
    else $error("change not reported once");

  // Push happens only after an accepted change
  a_push_cause: assert property (@(posedge clock) disable iff (rst)
    change_push |-> $past(accept))
    else $error("change pushed without acceptance");

  // Interrupt and push always travel together
  a_irq_pair: assert property (@(posedge clock) disable iff (rst)
    sig_change_irq == change_push)
    else $error("interrupt and push differ");

  // Pushed address is this slot pair
  a_change_addr: assert property (@(posedge clock) disable iff (rst)
    change_push |-> change_addr == TS_ADDR)
    else $error("change address wrong");

  // A value equal to the stable one is never reported
  a_no_accept_same: assert property (@(posedge clock) disable iff (rst)
    up_odd_strobe && sig_up && (ul_byte & mask) == (stable & mask)
    |=> !change_push)
    else $error("unchanged value reported");

  // Acceptance needs the same value at the previous sampling instant
  a_ll_double: assert property (@(posedge clock) disable iff (rst)
    accept |-> s.ll_prev == actual_new && s.ll_cnt == 8'h00)
    else $error("change accepted without double look");

  // Sampling instant stores the sample for the next look
  a_ll_store: assert property (@(posedge clock) disable iff (rst)
    sample_now |=> s.ll_prev == $past(actual_new))
    else $error("last-look sample not stored");

  // Sampling instant reloads the period counter
  a_ll_reload: assert property (@(posedge clock) disable iff (rst)
    sample_now && ll_period > 8'h01 |=> s.ll_cnt == $past(ll_period) - 8'h01)
    else $error("last-look period not reloaded");

  // Period of zero or one samples every frame
  a_ll_reload_one: assert property (@(posedge clock) disable iff (rst)
    sample_now && ll_period <= 8'h01 |=> s.ll_cnt == 8'h00)
    else $error("single frame period not kept");

  // Counter steps down once per frame between instants
  a_ll_count_down: assert property (@(posedge clock) disable iff (rst)
    up_odd_strobe && sig_up && s.ll_cnt != 8'h00
    |=> s.ll_cnt == $past(s.ll_cnt) - 8'h01)
    else $error("last-look counter not stepping");

  // Counter holds outside signaling odd slots
  a_ll_hold: assert property (@(posedge clock) disable iff (rst)
    !(up_odd_strobe && sig_up) |=> $stable(s.ll_cnt))
    else $error("last-look counter moved between frames");

endmodule
`default_nettype wire

// ==== testbench/scp_codec_model.sv ====
// Behavioural subscriber codec filter on the line side.
// Assumes strobes come from the preprocessor clock domain.
`timescale 1ns/1ps
`default_nettype none
module scp_codec_model (
  input wire logic clock,
  input wire logic ts_valid,
  input wire logic ts_odd,
  input wire logic [7:0] tx_sig,
  input wire logic [7:0] tx_mon,
  output logic [7:0] ul_byte
);
  logic [7:0] last;
  // Slot byte only while strobed, else the inverse of the last byte
  always_comb begin
    if (ts_valid)
      ul_byte = ts_odd ? tx_sig : tx_mon;
    else
      ul_byte = ~last;
  end
  // Remember the last byte put on the line
  always_ff @(posedge clock) begin
    if (ts_valid)
      last <= ul_byte;
  end
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Self-checking bench for the signaling channel preprocessor.
// Assumes the codec model on the line side and one 10 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import scp_pkg::*;
  localparam logic [7:0] TSA = 8'h5a; // Arbitrary slot address
  logic clock, rst, ts_valid, ts_odd, ack, rdy, hs_protocol, tri2, cm_wr;
  logic [7:0] ul_byte, mon_dn, pcm_dn, ll_period, cm_data, tx_sig, tx_mon;
  logic [7:0] dl_byte, mon_up, pcm_up, c_addr;
  logic [1:0] cm_addr, rd_addr, hs_up, oe_n;
  logic [3:0] cm_code;
  logic [11:0] rd_data;
  logic dl_valid, mon_v, pcm_v, push, irq;
  int failures = 0;
  int n_tests = 0;

  scp_preprocessor #(.TS_ADDR(TSA)) i_dut (.clock(clock), .rst(rst),
    .ts_valid(ts_valid), .ts_odd(ts_odd), .ul_byte(ul_byte),
    .mon_dn_byte(mon_dn), .monitor_receive_ack_bit(ack),
    .monitor_transmit_ready_bit(rdy), .hs_protocol(hs_protocol),
    .pcm_dn_byte(pcm_dn), .tristate_low2(tri2), .ll_period(ll_period),
    .cm_wr(cm_wr), .cm_addr(cm_addr), .cm_code(cm_code),
    .cm_data(cm_data), .cm_rd_addr(rd_addr), .dl_byte(dl_byte),
    .dl_valid(dl_valid), .mon_up_byte(mon_up), .mon_up_valid(mon_v),
    .mon_up_hs(hs_up), .pcm_up_byte(pcm_up), .pcm_up_low2_oe_n(oe_n),
    .pcm_up_valid(pcm_v), .change_push(push), .change_addr(c_addr),
    .sig_change_irq(irq), .cm_rd_data(rd_data));

  scp_codec_model i_codec (.clock(clock), .ts_valid(ts_valid),
    .ts_odd(ts_odd), .tx_sig(tx_sig), .tx_mon(tx_mon), .ul_byte(ul_byte));

  // Clock source
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic wr(input logic [1:0] a, input logic [3:0] c,
                    input logic [7:0] d);
    @(posedge clock);
    cm_wr <= 1'b1;
    cm_addr <= a;
    cm_code <= c;
    cm_data <= d;
    @(posedge clock);
    cm_wr <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, input logic [11:0] exp);
    @(posedge clock);
    rd_addr <= a;
    @(posedge clock);
    #1;
    chk(rd_data, exp);
  endtask

  // One slot strobe; returns just after the strobe edge
  task automatic slot(input logic odd);
    @(posedge clock);
    ts_valid <= 1'b1;
    ts_odd <= odd;
    @(posedge clock);
    ts_valid <= 1'b0;
    #1;
    chk(dl_valid, 1'b1);
  endtask

  // Even then odd slot with the given upstream signaling byte
  task automatic frame(input logic [7:0] v, input logic e);
    tx_sig = v;
    slot(1'b0);
    chk(dl_byte, mon_dn);
    chk({mon_v, mon_up}, {1'b1, tx_mon});
    slot(1'b1);
    chk({push, irq}, {e, e});
    chk(hs_up, v[1:0]);
  endtask

  task automatic s_down();
    wr(CM_DN_EVEN, CODE_SIG, 8'h47);
    wr(CM_DN_ODD, CODE_SIG8, 8'h00);
    repeat (2) begin
      frame(8'h03, 1'b0);
      chk(dl_byte, 8'h47);
    end
    wr(CM_DN_EVEN, CODE_SIG, 8'h8b);
    frame(8'h03, 1'b0);
    chk(dl_byte, 8'h8b);
    @(posedge clock);
    hs_protocol <= 1'b1;
    rdy <= 1'b1;
    frame(8'h03, 1'b0);
    chk(dl_byte, 8'h89);
  endtask

  task automatic s_transp();
    wr(CM_DN_ODD, CODE_SW64, 8'h00);
    wr(CM_UP_ODD, CODE_SW64, 8'h00);
    pcm_dn <= 8'hb7;
    ack <= 1'b1;
    rdy <= 1'b0;
    tri2 <= 1'b1;
    frame(8'h6d, 1'b0);
    chk(dl_byte, 8'hb6);
    chk({pcm_v, pcm_up, oe_n}, {1'b1, 8'h6d, 2'h3});
    tri2 <= 1'b0;
    frame(8'h6d, 1'b0);
    chk(oe_n, 2'h0);
    wr(CM_DN_ODD, CODE_SIG8, 8'h00);
    hs_protocol <= 1'b0;
  endtask

  task automatic s_up();
    wr(CM_UP_EVEN, CODE_SIG, 8'h00);
    wr(CM_UP_ODD, CODE_SIG, 8'h00);
    frame(8'h47, 1'b0);
    frame(8'h47, 1'b1);
    chk(c_addr, TSA);
    rd(CM_UP_ODD, {CODE_SIG, 8'h44});
    frame(8'h46, 1'b0);
    frame(8'h46, 1'b0);
    frame(8'h80, 1'b0);
    frame(8'h04, 1'b0);
    frame(8'h04, 1'b1);
    rd(CM_UP_EVEN, {CODE_SIG, 8'h04});
    wr(CM_UP_EVEN, CODE_SIG8, 8'h00);
    wr(CM_UP_ODD, CODE_SIG8, 8'h00);
    wr(CM_DN_EVEN, CODE_SIG, 8'h45);
    frame(8'h04, 1'b1);
    chk(dl_byte, 8'h45);
    frame(8'h05, 1'b0);
    frame(8'h05, 1'b1);
    rd(CM_UP_ODD, {CODE_SIG8, 8'h05});
    @(posedge clock);
    ll_period <= 8'h03;
    repeat (3) frame(8'h3c, 1'b0);
    frame(8'h3c, 1'b1);
  endtask

  // Inputs at time zero, reset, then the scenarios
  initial begin
    {rst, ts_valid, ts_odd, ack, rdy, hs_protocol, tri2, cm_wr} = 8'h80;
    {mon_dn, pcm_dn, cm_data, tx_sig} = 32'h3eff_0003;
    tx_mon = 8'h5c;
    ll_period = 8'h01;
    {cm_addr, rd_addr, cm_code} = 8'h00;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++)
      rd(2'(i), 12'h000);
    frame(8'h03, 1'b0);
    chk({dl_byte, oe_n}, {IDLE_BYTE, 2'h3});
    s_down();
    s_transp();
    s_up();
    results();
  end

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    results();
  end
endmodule
`default_nettype wire
